/* src/fct_pkg.sv */
// Package with register map and constants for the flash control tail block
//
// Notes on behaviour
// - The full written target word is the next erase/program location.
// - Wait enable bit 0 set adds fetch wait states; clear adds none.
// - Wait enable changes only after both key words arrive in order.
// - Only software changes fetch wait enable; it resets to zero.
// - Product code register is read-only; writes leave it unchanged.
// - Product code is a constant word fixed at manufacture.
// - Correct key sequence clears the lock bit; software may relock.
package fct_pkg;
	localparam logic [11:0] ADDR_UNLOCK_KEY = 12'h050;
	localparam logic [11:0] ADDR_LOCK_CTRL = 12'h058;
	localparam logic [11:0] ADDR_TARGET = 12'h054;
	localparam logic [11:0] ADDR_WAIT_CTRL = 12'h0fc;
	localparam logic [11:0] ADDR_PRODUCT = 12'h100;
	localparam logic [31:0] KEY_FIRST = 32'h45670123;
	localparam logic [31:0] KEY_SECOND = 32'hcdef89ab;
	localparam logic [31:0] TARGET_RESET = 32'h00000000;
	localparam int WAIT_EN_BIT = 0;
	localparam int LOCK_BIT = 0;
	localparam logic WAIT_EN_RESET = 1'b0;
	localparam logic LOCK_RESET = 1'b1;
	localparam logic [31:0] PRODUCT_CODE_DEFAULT = 32'h0000a5a5;
	localparam logic [1:0] KEY_IDLE = 2'h0;
endpackage

/* src/fct_key_unlock.sv */
// Key sequence detector driving the lock bit
`timescale 1ns/1ps
`default_nettype none
module fct_key_unlock (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_key_wr,
	input wire logic [31:0] i_key_data,
	input wire logic i_lock_set,
	output logic o_locked
);
	typedef enum logic [1:0] {
		FCT_KEY_WAIT1 = 2'b01,
		FCT_KEY_WAIT2 = 2'b10
	} fct_key_e;
	fct_key_e st_r, st_nxt;
	logic lock_r, lock_nxt;

	always_comb begin
		st_nxt = st_r;
		lock_nxt = lock_r;
		case (st_r)
			FCT_KEY_WAIT1: begin
				if (i_key_wr && i_key_data == fct_pkg::KEY_FIRST && lock_r)
					st_nxt = FCT_KEY_WAIT2;
			end
			FCT_KEY_WAIT2: begin
				if (i_key_wr) begin
					st_nxt = FCT_KEY_WAIT1;
					if (i_key_data == fct_pkg::KEY_SECOND)
						lock_nxt = 1'b0;
				end
			end
			default: st_nxt = FCT_KEY_WAIT1;
		endcase
		// Relock wins over a same-cycle unlock so protection is never lost
		if (i_lock_set) begin
			lock_nxt = 1'b1;
			st_nxt = FCT_KEY_WAIT1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_r <= FCT_KEY_WAIT1;
			lock_r <= fct_pkg::LOCK_RESET;
		end else begin
			st_r <= st_nxt;
			lock_r <= lock_nxt;
		end
	end

	assign o_locked = lock_r;

	a_wrong_key_stays: assert property (@(posedge i_clk) disable iff (i_rst)
		(st_r == FCT_KEY_WAIT1 && i_key_wr) |=> lock_r == $past(lock_r) || $past(i_lock_set) == 1'b0 && lock_r)
	else $error("single key write unlocked");
	a_unlock_order: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(lock_r) |-> $past(st_r) == FCT_KEY_WAIT2 && $past(i_key_data) == fct_pkg::KEY_SECOND)
	else $error("unlock without ordered keys");
	a_relock: assert property (@(posedge i_clk) disable iff (i_rst)
		i_lock_set |=> lock_r)
	else $error("lock set ignored");
endmodule // fct_key_unlock
`default_nettype wire

/* src/fct_regs.sv */
// APB register bank: target location, fetch wait control, product code
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fct_regs #(
	parameter logic [31:0] PRODUCT_CODE = fct_pkg::PRODUCT_CODE_DEFAULT
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic [31:0] o_target,
	output logic o_fetch_wait,
	output logic o_locked
);
	// Product code value is arbitrary, kept as a parameter
	logic [31:0] target_r, target_nxt;
	logic wait_r, wait_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic err_r, err_nxt;
	logic wr_acc, rd_acc, full_word, key_wr, lock_set, locked;

	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = a == fct_pkg::ADDR_UNLOCK_KEY
			|| a == fct_pkg::ADDR_LOCK_CTRL || a == fct_pkg::ADDR_TARGET
			|| a == fct_pkg::ADDR_WAIT_CTRL || a == fct_pkg::ADDR_PRODUCT;
	endfunction

	// One setup cycle, then access; write data taken at the access edge, read data registered at the setup edge
	assign wr_acc = i_psel && i_penable && i_pwrite;
	assign rd_acc = i_psel && !i_penable && !i_pwrite;
	assign full_word = i_pstrb == 4'hf;
	assign key_wr = wr_acc && full_word && i_paddr == fct_pkg::ADDR_UNLOCK_KEY;
	assign lock_set = wr_acc && full_word && i_paddr == fct_pkg::ADDR_LOCK_CTRL
		&& i_pwdata[fct_pkg::LOCK_BIT];

	fct_key_unlock u_key (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_key_wr(key_wr),
		.i_key_data(i_pwdata),
		.i_lock_set(lock_set),
		.o_locked(locked)
	);

	always_comb begin
		target_nxt = target_r;
		wait_nxt = wait_r;
		rdata_nxt = rdata_r;
		err_nxt = 1'b0;
		if (wr_acc) begin
			// Partial words are refused, so the target is always whole
			if (!full_word || !is_mapped(i_paddr))
				err_nxt = 1'b0;
			else if (i_paddr == fct_pkg::ADDR_TARGET)
				target_nxt = i_pwdata;
			else if (i_paddr == fct_pkg::ADDR_WAIT_CTRL && !locked)
				wait_nxt = i_pwdata[fct_pkg::WAIT_EN_BIT];
		end
		if (i_psel && !i_penable) begin
			err_nxt = !is_mapped(i_paddr) || (i_pwrite && !full_word);
			rdata_nxt = 32'h00000000;
			if (rd_acc) begin
				case (i_paddr)
					fct_pkg::ADDR_WAIT_CTRL:
						rdata_nxt = {31'h0, wait_r};
					fct_pkg::ADDR_LOCK_CTRL:
						rdata_nxt = {31'h0, locked};
					fct_pkg::ADDR_PRODUCT:
						rdata_nxt = PRODUCT_CODE;
					default: rdata_nxt = 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			target_r <= fct_pkg::TARGET_RESET;
			wait_r <= fct_pkg::WAIT_EN_RESET;
			rdata_r <= 32'h00000000;
			err_r <= 1'b0;
		end else begin
			target_r <= target_nxt;
			wait_r <= wait_nxt;
			rdata_r <= rdata_nxt;
			err_r <= err_nxt;
		end
	end

	assign o_prdata = rdata_r;
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && err_r;
	assign o_target = target_r;
	assign o_fetch_wait = wait_r;
	assign o_locked = locked;

	a_wait_locked: assert property (@(posedge i_clk) disable iff (i_rst)
		locked |=> wait_r == $past(wait_r))
	else $error("wait enable changed while locked");
	a_target_write: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_acc && full_word && i_paddr == fct_pkg::ADDR_TARGET)
		|=> target_r == $past(i_pwdata))
	else $error("target not stored");
	a_product_read: assert property (@(posedge i_clk) disable iff (i_rst)
		(rd_acc && i_paddr == fct_pkg::ADDR_PRODUCT)
		|=> o_prdata == PRODUCT_CODE)
	else $error("product code wrong");
	a_wait_only_sw: assert property (@(posedge i_clk) disable iff (i_rst)
		!wr_acc |=> $stable(wait_r))
	else $error("wait enable changed by hardware");
	a_wait_out: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_acc && full_word && i_paddr == fct_pkg::ADDR_WAIT_CTRL && !locked)
		|=> o_fetch_wait == $past(i_pwdata[fct_pkg::WAIT_EN_BIT]))
	else $error("fetch wait output mismatch");
	// Refused partial words must leave every stored bit alone
	a_partial_refused: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_acc && !full_word) |=> $stable(target_r) && $stable(wait_r))
	else $error("partial write changed state");
	a_product_write: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_acc && i_paddr == fct_pkg::ADDR_PRODUCT)
		|=> $stable(target_r) && $stable(wait_r))
	else $error("product code write had effect");
	a_wait_reset: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(i_rst) |-> !wait_r)
	else $error("wait enable not zero after reset");
endmodule // fct_regs
`default_nettype wire

/* tb/flash_ctrl_tail_registers_test.sv */
// Self-checking bench for the flash control tail register bank
`timescale 1ns/1ps
`default_nettype none
module flash_ctrl_tail_registers_test;
	localparam logic [31:0] CODE = 32'h1357c0de; // Arbitrary product code
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_psel = 1'b0;
	logic i_penable = 1'b0;
	logic i_pwrite = 1'b0;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h00000000;
	logic [3:0] i_pstrb = 4'hf;
	logic [31:0] o_prdata, o_target, rd, tgt;
	logic o_pready, o_pslverr, o_fetch_wait, o_locked, err;
	int miscompares = 0;
	int check_count = 0;
	always #12.5 i_clk = ~i_clk;
	fct_regs #(.PRODUCT_CODE(CODE)) fct_regs_inst (.i_clk(i_clk),
		.i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .o_target(o_target),
		.o_fetch_wait(o_fetch_wait), .o_locked(o_locked));
	// Wait enable only follows a write while unlocked
	function automatic logic exp_wait(input logic lk, input logic cur,
		input logic wr);
		return lk ? cur : wr;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Ends at the falling edge so registered outputs have settled
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		i_pstrb <= s;
		@(posedge i_clk);
		i_penable <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 50);
		rd = o_prdata;
		err = o_pslverr;
		if (n >= 50) miscompares++;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(negedge i_clk);
	endtask
	task automatic end_of_test;
		if (miscompares == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		miscompares++;
		end_of_test;
	end
	initial begin
		void'($urandom(65));
		repeat (12) @(posedge i_clk);
		i_rst <= 1'b0;
		@(negedge i_clk);
		chk(o_target, 32'h00000000);
		chk(32'({o_locked, o_fetch_wait}), 32'h00000002);
		for (int i = 0; i < 4; i++) begin
			tgt = $urandom;
			apb(1'b1, fct_pkg::ADDR_TARGET, tgt, 4'hf);
			chk(o_target, tgt);
		end
		// Partial strobes are refused and leave the target alone
		apb(1'b1, fct_pkg::ADDR_TARGET, ~tgt, 4'h3);
		chk({31'h0, err} ^ o_target, {31'h0, 1'b1} ^ tgt);
		apb(1'b1, fct_pkg::ADDR_WAIT_CTRL, 32'h1, 4'hf);
		chk(32'(o_fetch_wait), 32'(exp_wait(1'b1, 1'b0, 1'b1)));
		apb(1'b1, fct_pkg::ADDR_UNLOCK_KEY, fct_pkg::KEY_SECOND, 4'hf);
		apb(1'b1, fct_pkg::ADDR_UNLOCK_KEY, fct_pkg::KEY_FIRST, 4'hf);
		apb(1'b1, fct_pkg::ADDR_WAIT_CTRL, 32'h1, 4'hf);
		chk(32'({o_locked, o_fetch_wait}), 32'h00000002);
		// A stray key write only restarts the sequence, so begin afresh
		apb(1'b1, fct_pkg::ADDR_UNLOCK_KEY, fct_pkg::KEY_FIRST, 4'hf);
		apb(1'b1, fct_pkg::ADDR_UNLOCK_KEY, fct_pkg::KEY_FIRST, 4'hf);
		apb(1'b1, fct_pkg::ADDR_UNLOCK_KEY, fct_pkg::KEY_SECOND, 4'hf);
		chk(32'(o_locked), 32'h00000000);
		apb(1'b1, fct_pkg::ADDR_WAIT_CTRL, 32'h1, 4'hf);
		chk(32'(o_fetch_wait), 32'(exp_wait(1'b0, 1'b0, 1'b1)));
		apb(1'b0, fct_pkg::ADDR_WAIT_CTRL, 32'h0, 4'hf);
		chk(rd, 32'h00000001);
		apb(1'b1, fct_pkg::ADDR_LOCK_CTRL, 32'h1, 4'hf);
		chk(32'(o_locked), 32'h00000001);
		apb(1'b1, fct_pkg::ADDR_WAIT_CTRL, 32'h0, 4'hf);
		chk(32'(o_fetch_wait), 32'(exp_wait(1'b1, 1'b1, 1'b0)));
		apb(1'b1, fct_pkg::ADDR_PRODUCT, ~CODE, 4'hf);
		apb(1'b0, fct_pkg::ADDR_PRODUCT, 32'h0, 4'hf);
		chk(rd, CODE);
		apb(1'b0, fct_pkg::ADDR_PRODUCT, 32'h0, 4'hf);
		chk(rd, CODE);
		apb(1'b0, 12'h200, 32'h0, 4'hf);
		chk(32'(err), 32'h00000001);
		end_of_test;
	end
endmodule // flash_ctrl_tail_registers_test
`default_nettype wire
